// ---- design/regulator_startup_sequencer_cfg.svh ----
// register map, field positions, reset values and timing counts of the start-up sequencer
`ifndef REGULATOR_STARTUP_SEQUENCER_CFG_SVH
`define REGULATOR_STARTUP_SEQUENCER_CFG_SVH
// register byte offsets
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_IRQ_STS 8'h08
`define REG_IRQ_MASK 8'h0c
// control fields
`define CTRL_SW_EN 0
`define CTRL_RST_SW_EN 1'b1
// status fields
`define STS_STATE_LSB 0
`define STS_PG 3
`define STS_SLEEP 4
`define STS_EN 5
`define STS_GATE 6
`define STS_RAMP 7
`define STS_SEL_LSB 8
// interrupt status and mask fields
`define IRQ_PG_RISE 0
`define IRQ_PG_FALL 1
`define IRQ_DISCH 2
`define IRQ_RAMP_DONE 3
`define IRQ_W 4
`define IRQ_RST_MASK 4'h0
// timing: system clock and switching oscillator rates
`define CLK_FREQ_KHZ 50000
`define OSC_FREQ_KHZ 500
`define OSC_DIV_CYC (`CLK_FREQ_KHZ / `OSC_FREQ_KHZ)
// counts in oscillator cycles
`define START_TICKS 32
`define DISCH_TICKS 256
`define PG_DELAY_TICKS 64
// stage masks per selection
`define STAGE_N 10
`define STAGE_MASK_10 10'h03ff
`define STAGE_MASK_4 10'h0078
`define STAGE_MASK_2 10'h0030
`define STAGE_MASK_OFF 10'h0000
`endif

// ---- design/regulator_startup_sequencer_pkg.sv ----
// types shared by the start-up sequencer modules
package regulator_startup_sequencer_pkg;
  // gray coded along off, delay, ramp, pg delay, run, discharge
  typedef enum logic [2:0] {
    ST_OFF = 3'h0,
    ST_DELAY = 3'h1,
    ST_RAMP = 3'h3,
    ST_PGDLY = 3'h2,
    ST_RUN = 3'h6,
    ST_DISCH = 3'h7
  } seq_state_t;
  typedef enum logic [1:0] {
    SEL_TEN = 2'h0,
    SEL_FOUR = 2'h1,
    SEL_TWO = 2'h2,
    SEL_SLEEP = 2'h3
  } stage_sel_t;
  typedef enum logic [1:0] {
    RESP_OKAY = 2'h0,
    RESP_SLVERR = 2'h2
  } axi_resp_t;
endpackage

// ---- design/stage_if.sv ----
// stage selection carrier between sequencer and stage decoder
`timescale 1ns/10ps
`default_nettype none
interface stage_if;
  logic [1:0] sel;
  logic [9:0] mask;
  logic sleep;
  modport dec (input sel, output mask, output sleep);
  modport user (output sel, input mask, input sleep);
endinterface
`default_nettype wire

// ---- design/input_sync.sv ----
// two-flop synchroniser bank for asynchronous pins
`timescale 1ns/10ps
`default_nettype none
module input_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_t;
  sync_t r_q;
  sync_t r_d;
  // first stage feeds only the second stage
  always_comb
  begin
    r_d.s1 = d;
    r_d.s2 = r_q.s1;
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      r_q <= '0;
    else
      r_q <= r_d;
  end
  assign q = r_q.s2;
endmodule
`default_nettype wire

// ---- design/stage_decoder.sv ----
// decodes the two select pins into per-stage drive enables
`timescale 1ns/10ps
`default_nettype none
`include "regulator_startup_sequencer_cfg.svh"
module stage_decoder
  import regulator_startup_sequencer_pkg::*;
(
  stage_if.dec sif
);
  logic [9:0] sel_mask;
  // whole-mask choice; sensing stages sit in every non-sleep mask
  always_comb
  begin
    case (stage_sel_t'(sif.sel))
      SEL_TEN: sel_mask = `STAGE_MASK_10;
      SEL_FOUR: sel_mask = `STAGE_MASK_4;
      SEL_TWO: sel_mask = `STAGE_MASK_2;
      default: sel_mask = `STAGE_MASK_OFF;
    endcase
  end
  // one enable per stage
  for (genvar i = 0; i < `STAGE_N; i++)
  begin : g_stage
    assign sif.mask[i] = sel_mask[i];
  end
  assign sif.sleep = (sif.sel == SEL_SLEEP);
endmodule
`default_nettype wire

// ---- design/regulator_startup_sequencer.sv ----
// start-up and shutdown sequencer of a buck regulator with axi4-lite registers
`timescale 1ns/10ps
`default_nettype none
`include "regulator_startup_sequencer_cfg.svh"
module regulator_startup_sequencer
  import regulator_startup_sequencer_pkg::*;
#(
  parameter int OSC_DIV = `OSC_DIV_CYC,
  parameter int START_TICKS = `START_TICKS,
  parameter int DISCH_TICKS = `DISCH_TICKS,
  parameter int PG_DELAY_TICKS = `PG_DELAY_TICKS
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic enable_in,
  input wire logic gate_cmp,
  input wire logic ramp_done_cmp,
  input wire logic stage_select_a,
  input wire logic stage_select_b,
  output logic output_ok_flag,
  output logic output_ok_flag_oe,
  output logic [9:0] phase_output_en,
  output logic ramp_discharge,
  output logic ramp_charge,
  output logic gate_sink_on,
  output logic stage_sleep,
  output logic irq,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam logic [15:0] DIV_LAST = 16'(OSC_DIV - 1);
  localparam logic [15:0] START_LAST = 16'(START_TICKS - 1);
  localparam logic [15:0] DISCH_LAST = 16'(DISCH_TICKS - 1);
  localparam logic [15:0] PGDLY_LAST = 16'(PG_DELAY_TICKS - 1);

  typedef struct packed {
    seq_state_t st;
    logic [15:0] div;
    logic tick;
    logic [15:0] cnt;
    logic pg_rel;
    logic disch;
    logic charge;
    logic sink;
    logic [9:0] stage_en;
    logic sleep;
    logic sw_en;
    logic [`IRQ_W-1:0] irq_sts;
    logic [`IRQ_W-1:0] irq_msk;
    logic irq;
    logic aw_hold;
    logic w_hold;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } seq_t;

  seq_t q;
  seq_t n;
  logic [1:0] rst_sync_q;
  logic rst_n;
  logic [4:0] pins_s;
  logic en_s;
  logic gate_s;
  logic ramp_s;
  logic go;
  logic active_n;
  logic [`IRQ_W-1:0] ev;
  logic [`IRQ_W-1:0] clr;
  logic [31:0] rd_word;
  logic rd_ok;
  stage_if sif ();

  // reset release through two flops; assertion is asynchronous
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      rst_sync_q <= 2'h0;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n = rst_sync_q[1];

  // all pins come from outside the clock domain
  input_sync #(
    .W(5)
  ) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d({stage_select_b, stage_select_a, ramp_done_cmp, gate_cmp, enable_in}),
    .q(pins_s)
  );
  assign en_s = pins_s[0];
  assign gate_s = pins_s[1];
  assign ramp_s = pins_s[2];
  assign sif.sel = pins_s[4:3];

  stage_decoder u_dec (
    .sif(sif)
  );

  // register read mux
  always_comb
  begin
    rd_word = 32'h0000_0000;
    rd_ok = 1'b1;
    case (s_axi_araddr)
      `REG_CTRL: rd_word[`CTRL_SW_EN] = q.sw_en;
      `REG_STATUS:
      begin
        rd_word[`STS_STATE_LSB +: 3] = q.st;
        rd_word[`STS_PG] = q.pg_rel;
        rd_word[`STS_SLEEP] = q.sleep;
        rd_word[`STS_EN] = en_s;
        rd_word[`STS_GATE] = gate_s;
        rd_word[`STS_RAMP] = ramp_s;
        rd_word[`STS_SEL_LSB +: 2] = sif.sel;
      end
      `REG_IRQ_STS: rd_word[`IRQ_W-1:0] = q.irq_sts;
      `REG_IRQ_MASK: rd_word[`IRQ_W-1:0] = q.irq_msk;
      default: rd_ok = 1'b0;
    endcase
  end

  // next state of sequencer, register file and bus slave
  always_comb
  begin
    n = q;
    ev = '0;
    clr = '0;
    // start needs enable and gate comparator together
    go = en_s & gate_s & q.sw_en;
    // oscillator cycle enable; all sequencer counts step on it
    n.tick = 1'b0;
    if (q.div >= DIV_LAST)
    begin
      n.div = 16'h0000;
      n.tick = 1'b1;
    end
    else
      n.div = q.div + 16'h0001;
    if (q.tick)
      n.cnt = q.cnt + 16'h0001;
    case (q.st)
      ST_OFF:
      begin
        if (go)
        begin
          n.st = ST_DELAY;
          n.cnt = 16'h0000;
        end
      end
      ST_DELAY:
      begin
        if (!go)
        begin
          n.st = ST_DISCH;
          n.cnt = 16'h0000;
        end
        else if (q.tick && q.cnt == START_LAST)
        begin
          n.st = ST_RAMP;
          n.cnt = 16'h0000;
        end
      end
      ST_RAMP:
      begin
        if (!go)
        begin
          n.st = ST_DISCH;
          n.cnt = 16'h0000;
        end
        else if (ramp_s)
        begin
          n.st = ST_PGDLY;
          n.cnt = 16'h0000;
          ev[`IRQ_RAMP_DONE] = 1'b1;
        end
      end
      ST_PGDLY:
      begin
        if (!go)
        begin
          n.st = ST_DISCH;
          n.cnt = 16'h0000;
        end
        else if (q.tick && q.cnt == PGDLY_LAST)
          n.st = ST_RUN;
      end
      ST_RUN:
      begin
        if (!go)
        begin
          n.st = ST_DISCH;
          n.cnt = 16'h0000;
        end
      end
      ST_DISCH:
      begin
        // full discharge even if conditions return early
        if (q.tick && q.cnt == DISCH_LAST)
          n.st = ST_OFF;
      end
      default:
      begin
        n.st = ST_OFF;
        n.cnt = 16'h0000;
      end
    endcase
    if (n.st == ST_DISCH && q.st != ST_DISCH)
      ev[`IRQ_DISCH] = 1'b1;
    // output flops other than sink and sleep follow the next state so they switch with it
    active_n = (n.st == ST_RAMP) || (n.st == ST_PGDLY) || (n.st == ST_RUN);
    n.pg_rel = (n.st == ST_RUN) && en_s;
    n.disch = (n.st == ST_OFF) || (n.st == ST_DISCH);
    n.charge = active_n;
    n.sink = !gate_s;
    // stage drives only while switching; zero means high impedance
    n.stage_en = active_n ? sif.mask : 10'h000;
    n.sleep = sif.sleep;
    ev[`IRQ_PG_RISE] = n.pg_rel & ~q.pg_rel;
    ev[`IRQ_PG_FALL] = ~n.pg_rel & q.pg_rel;

    // write channel: address and data taken in either order
    if (s_axi_awvalid && q.awready)
    begin
      n.aw_hold = 1'b1;
      n.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && q.wready)
    begin
      n.w_hold = 1'b1;
      n.wdata = s_axi_wdata;
      n.wstrb = s_axi_wstrb;
    end
    if (q.aw_hold && q.w_hold && !q.bvalid)
    begin
      n.aw_hold = 1'b0;
      n.w_hold = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = RESP_OKAY;
      // all writable fields live in byte lane 0
      case (q.awaddr)
        `REG_CTRL:
          if (q.wstrb[0])
            n.sw_en = q.wdata[`CTRL_SW_EN];
        `REG_STATUS: n.bresp = RESP_OKAY;
        `REG_IRQ_STS:
          if (q.wstrb[0])
            clr = q.wdata[`IRQ_W-1:0];
        `REG_IRQ_MASK:
          if (q.wstrb[0])
            n.irq_msk = q.wdata[`IRQ_W-1:0];
        default: n.bresp = RESP_SLVERR;
      endcase
    end
    if (q.bvalid && s_axi_bready)
      n.bvalid = 1'b0;
    n.awready = !n.aw_hold && !n.bvalid;
    n.wready = !n.w_hold && !n.bvalid;

    // read channel: one outstanding read
    if (s_axi_arvalid && q.arready)
    begin
      n.arready = 1'b0;
      n.rvalid = 1'b1;
      n.rdata = rd_word;
      n.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
    end
    if (q.rvalid && s_axi_rready)
    begin
      n.rvalid = 1'b0;
      n.arready = 1'b1;
    end

    // sticky events; a new event beats a same-cycle clear
    n.irq_sts = (q.irq_sts & ~clr) | ev;
    n.irq = |(n.irq_sts & n.irq_msk);
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q <= '0;
      q.st <= ST_OFF;
      q.disch <= 1'b1;
      q.sink <= 1'b1;
      q.sw_en <= `CTRL_RST_SW_EN;
      q.irq_msk <= `IRQ_RST_MASK;
      q.awready <= 1'b1;
      q.wready <= 1'b1;
      q.arready <= 1'b1;
    end
    else
      q <= n;
  end

  // open-drain flag: drives low until released
  assign output_ok_flag = 1'b0;
  assign output_ok_flag_oe = !q.pg_rel;
  assign phase_output_en = q.stage_en;
  assign ramp_discharge = q.disch;
  assign ramp_charge = q.charge;
  assign gate_sink_on = q.sink;
  assign stage_sleep = q.sleep;
  assign irq = q.irq;
  assign s_axi_awready = q.awready;
  assign s_axi_wready = q.wready;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = q.arready;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // gate low while off keeps the device off
  property p_stay_off;
    (q.st == ST_OFF && !gate_s) |=> (q.st == ST_OFF);
  endproperty
  a_stay_off: assert property (p_stay_off) else $error("left shutdown with gate low");

  // start delay cut short by a failing gate, straight into discharge
  property p_gate_checked;
    (q.st == ST_DELAY && !gate_s) |=> (q.st == ST_DISCH);
  endproperty
  a_gate_checked: assert property (p_gate_checked) else $error("delay went on with gate low");

  property p_shutdown_hiz;
    !en_s |=> (phase_output_en == 10'h000);
  endproperty
  a_shutdown_hiz: assert property (p_shutdown_hiz) else $error("stage driven with enable low");

  property p_sink;
    ##1 (gate_sink_on == !$past(gate_s));
  endproperty
  a_sink: assert property (p_sink) else $error("gate sink does not follow comparator");

  property p_start_delay;
    (q.st == ST_DELAY && q.cnt < START_LAST) |=> (q.st != ST_RAMP);
  endproperty
  a_start_delay: assert property (p_start_delay) else $error("ramp started before 32 cycles");

  property p_ramp_done;
    (q.st == ST_RAMP && go && ramp_s) |=> (q.st == ST_PGDLY && !output_ok_flag_oe == 1'b0);
  endproperty
  a_ramp_done: assert property (p_ramp_done) else $error("ramp end not taken");

  property p_pg_after_delay;
    $rose(q.pg_rel) |-> ($past(q.st) == ST_PGDLY && $past(q.cnt) == PGDLY_LAST);
  endproperty
  a_pg_after_delay: assert property (p_pg_after_delay) else $error("flag released early");

  property p_disch_hold;
    (q.st == ST_DISCH && q.cnt < DISCH_LAST) |=> (q.st == ST_DISCH && ramp_discharge);
  endproperty
  a_disch_hold: assert property (p_disch_hold) else $error("discharge ended early");

  property p_pg_drop;
    !en_s |=> output_ok_flag_oe;
  endproperty
  a_pg_drop: assert property (p_pg_drop) else $error("flag not pulled low on enable loss");

  property p_stage_count;
    (phase_output_en != 10'h000) |-> ($countones(phase_output_en) inside {2, 4, 10});
  endproperty
  a_stage_count: assert property (p_stage_count) else $error("illegal stage count");

  property p_restart;
    (q.st == ST_DISCH && q.tick && q.cnt == DISCH_LAST) |=> (q.st == ST_OFF);
  endproperty
  a_restart: assert property (p_restart) else $error("no return to shutdown");

  property p_sense_stages;
    (ramp_charge && !stage_sleep) |-> (phase_output_en[5:4] == 2'h3);
  endproperty
  a_sense_stages: assert property (p_sense_stages) else $error("sensing stages off");

  property p_sleep_off;
    stage_sleep |-> (phase_output_en == 10'h000);
  endproperty
  a_sleep_off: assert property (p_sleep_off) else $error("stage on in sleep");
endmodule
`default_nettype wire

// ---- bench/startup_partner.sv ----
// far-side model: enable source, supply gate comparator, ramp node and flag pull-up
`timescale 1ns/10ps
`default_nettype none
module startup_partner #(
  parameter int RAMP_CYC = 10
) (
  input wire logic clk,
  input wire logic en_cmd,
  input wire logic vin_ok,
  input wire logic ramp_charge,
  input wire logic output_ok_flag,
  input wire logic output_ok_flag_oe,
  output logic enable_in,
  output logic gate_cmp,
  output logic ramp_done_cmp,
  output logic flag_pin
);
  int ramp_cnt;
  // pins settle at the first edge, while the device is still held in reset;
  // one process drives each pin
  // ramp node meets reference a while into charging, falls as soon as charging stops
  always @(posedge clk)
  begin
    enable_in <= en_cmd;
    gate_cmp <= vin_ok;
    ramp_cnt <= ramp_charge ? ramp_cnt + 1 : 0;
    ramp_done_cmp <= ramp_charge && ramp_cnt >= RAMP_CYC;
  end
  // open drain with pull-up: a released pin reads high
  assign flag_pin = output_ok_flag_oe ? output_ok_flag : 1'b1;
endmodule
`default_nettype wire

// ---- bench/regulator_startup_sequencer_tb.sv ----
// self-checking bench for the regulator start-up sequencer
`timescale 1ns/10ps
`default_nettype none
`include "regulator_startup_sequencer_cfg.svh"
module regulator_startup_sequencer_tb
  import regulator_startup_sequencer_pkg::*;
();
  // short counts keep the run brief; every timing window but the 1 to 5 cycle flag drop scales from them
  localparam int DIV = 2;
  localparam int ST = 32;
  localparam int DT = 8;
  localparam int PT = 4;
  typedef struct packed {
    logic [1:0] sel;
    logic [9:0] mask;
    logic slp;
  } row_t;
  logic clk, arst_n, en_cmd, vin_ok, stage_select_a, stage_select_b;
  logic enable_in, gate_cmp, ramp_done_cmp, flag_pin, output_ok_flag, output_ok_flag_oe;
  logic ramp_discharge, ramp_charge, gate_sink_on, stage_sleep, irq;
  logic [9:0] phase_output_en;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int fails, checks, cyc, n;
  row_t rows [4];

  regulator_startup_sequencer #(
    .OSC_DIV(DIV),
    .START_TICKS(ST),
    .DISCH_TICKS(DT),
    .PG_DELAY_TICKS(PT)
  ) i_dut (
    .clk, .arst_n, .enable_in, .gate_cmp, .ramp_done_cmp, .stage_select_a, .stage_select_b,
    .output_ok_flag, .output_ok_flag_oe, .phase_output_en, .ramp_discharge, .ramp_charge,
    .gate_sink_on, .stage_sleep, .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready
  );
  startup_partner #(.RAMP_CYC(10)) i_far (.clk, .en_cmd, .vin_ok, .ramp_charge, .output_ok_flag,
    .output_ok_flag_oe, .enable_in, .gate_cmp, .ramp_done_cmp, .flag_pin);

  // 50 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // hang guard, far above the several hundred cycles the tests need
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      fails++;
      final_report();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rng(input int lo, input int hi);
    chk(32'(n >= lo && n <= hi), 32'h1);
  endtask
  // counts edges until a chosen output reaches a level; the hang guard bounds it
  task automatic until_lvl(input int s, input logic v);
    n = 0;
    while ((s == 0 ? ramp_charge : s == 1 ? flag_pin : s == 2 ? ramp_discharge : ramp_done_cmp) !== v)
    begin
      @(posedge clk);
      n++;
    end
  endtask
  // write: both channels offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input axi_resp_t er);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (s_axi_awvalid || s_axi_wvalid);
    while (s_axi_bvalid !== 1'b1)
      @(posedge clk);
    s_axi_bready <= 1'b0;
    chk(32'(s_axi_bresp), 32'(er));
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input axi_resp_t er);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
      @(posedge clk);
    while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1)
      @(posedge clk);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, e);
    chk(32'(s_axi_rresp), 32'(er));
  endtask
  task final_report;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // main sequence: reset, start-up, selection table, refusals, shutdown paths
  initial
  begin
    {arst_n, en_cmd, vin_ok, stage_select_a, stage_select_b} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    rows[0] = '{SEL_TEN, `STAGE_MASK_10, 1'b0};
    rows[1] = '{SEL_FOUR, `STAGE_MASK_4, 1'b0};
    rows[2] = '{SEL_TWO, `STAGE_MASK_2, 1'b0};
    rows[3] = '{SEL_SLEEP, `STAGE_MASK_OFF, 1'b1};
    repeat (5) @(posedge clk);
    chk(32'({flag_pin, phase_output_en, ramp_discharge, ramp_charge, irq}), 32'h4);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd(`REG_CTRL, 32'h1, RESP_OKAY);
    rd(`REG_IRQ_MASK, 32'h0, RESP_OKAY);
    rd(`REG_STATUS, 32'h0, RESP_OKAY);
    $display("test reset done");
    // enable alone must not start anything while the supply gate is low
    en_cmd <= 1'b1;
    repeat (60) @(posedge clk);
    chk(32'({ramp_charge, gate_sink_on, flag_pin}), 32'h2);
    rd(`REG_STATUS, 32'h20, RESP_OKAY);
    wr(`REG_IRQ_MASK, 32'h1, RESP_OKAY);
    vin_ok <= 1'b1;
    until_lvl(0, 1'b1);
    rng(ST * DIV - DIV, ST * DIV + DIV + 6);
    chk(32'({phase_output_en, gate_sink_on}), 32'({`STAGE_MASK_10, 1'b0}));
    until_lvl(3, 1'b1);
    chk(32'(flag_pin), 32'h0);
    until_lvl(1, 1'b1);
    rng(PT * DIV - DIV, PT * DIV + DIV + 5);
    repeat (3) @(posedge clk);
    chk(32'(irq), 32'h1);
    rd(`REG_IRQ_STS, 32'h9, RESP_OKAY);
    wr(`REG_IRQ_STS, 32'h1, RESP_OKAY);
    repeat (2) @(posedge clk);
    chk(32'(irq), 32'h0);
    rd(`REG_IRQ_STS, 32'h8, RESP_OKAY);
    $display("test start-up done");
    // selection table while running
    foreach (rows[i])
    begin
      {stage_select_b, stage_select_a} <= rows[i].sel;
      repeat (5) @(posedge clk);
      chk(32'(phase_output_en), 32'(rows[i].mask));
      chk(32'(stage_sleep), 32'(rows[i].slp));
      rd(`REG_STATUS, 32'({rows[i].sel, 3'h7, rows[i].slp, 4'he}), RESP_OKAY);
      @(posedge clk);
    end
    {stage_select_b, stage_select_a} <= 2'h0;
    $display("test selection done");
    // unmapped place and read-only status
    wr(8'h40, 32'h1, RESP_SLVERR);
    rd(8'h40, 32'h0, RESP_SLVERR);
    wr(`REG_STATUS, 32'h0, RESP_OKAY);
    rd(`REG_STATUS, 32'hee, RESP_OKAY);
    $display("test bus refusal done");
    // enable drop: flag falls at once, stages off and discharge on, restart no sooner than the start delay
    en_cmd <= 1'b0;
    until_lvl(1, 1'b0);
    rng(1, 5);
    chk(32'({phase_output_en, ramp_discharge}), 32'h1);
    rd(`REG_IRQ_STS, 32'he, RESP_OKAY);
    chk(32'(irq), 32'h0);
    en_cmd <= 1'b1;
    until_lvl(0, 1'b1);
    rng(ST * DIV, 2000);
    $display("test enable drop done");
    // gate failure mid-ramp, gate back at once
    vin_ok <= 1'b0;
    until_lvl(2, 1'b1);
    chk(32'({gate_sink_on, ramp_charge}), 32'h2);
    vin_ok <= 1'b1;
    until_lvl(2, 1'b0);
    rng(DT * DIV - DIV, DT * DIV + DIV + 3);
    until_lvl(0, 1'b1);
    rng(ST * DIV - DIV, ST * DIV + DIV + 2);
    $display("test gate failure done");
    // a write with lane 0 off changes nothing; software enable clear stops the ramp
    s_axi_wstrb <= 4'h0;
    wr(`REG_IRQ_MASK, 32'h0, RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    rd(`REG_IRQ_MASK, 32'h1, RESP_OKAY);
    wr(`REG_CTRL, 32'h0, RESP_OKAY);
    until_lvl(2, 1'b1);
    chk(32'({phase_output_en, ramp_charge}), 32'h0);
    rd(`REG_CTRL, 32'h0, RESP_OKAY);
    wr(`REG_CTRL, 32'h1, RESP_OKAY);
    until_lvl(0, 1'b1);
    rng(ST * DIV - DIV, 2000);
    $display("test software enable done");
    // second reset in mid-ramp
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk(32'({flag_pin, phase_output_en, ramp_discharge, ramp_charge, irq}), 32'h4);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd(`REG_IRQ_MASK, 32'h0, RESP_OKAY);
    $display("test second reset done");
    final_report();
  end
endmodule
`default_nettype wire
